// *** design/caf_pkg.sv ***
// Shared constants, record layouts and state codes of the acceptance filter.
// Assumes a single module clock; every user compiles this package first.
package caf_pkg;

  // Sizes of the filter bank
  localparam int NUM_FILTERS = 32;
  localparam int NUM_MASKS = 4;
  localparam int NUM_RX_FIFOS = 32;
  localparam int FILT_IDX_W = 5;
  localparam int MASK_SEL_W = 2;
  localparam int FIFO_SEL_W = 5;
  localparam int SID_W = 11;
  localparam int EID_W = 18;
  localparam int DATA_W = 64;
  localparam int RX_BUF_DEPTH = 8;

  // Operating mode field codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_DISABLE = 3'h1;
  localparam logic [2:0] MODE_CONFIG = 3'h4;

  // Filter control byte: enable bit 7, mask select 6:5, fifo select 4:0
  typedef struct packed {
    logic filter_enable_bit;
    logic [MASK_SEL_W-1:0] mask_select_field;
    logic [FIFO_SEL_W-1:0] fifo_select_field;
  } caf_filt_ctrl_t;

  // Filter word: sid 31:21, extended enable at 19, eid 17:0
  typedef struct packed {
    logic [SID_W-1:0] sid;
    logic rsv_20;
    logic extended_id_enable;
    logic rsv_18;
    logic [EID_W-1:0] eid;
  } caf_filt_id_t;

  // Mask word: sid 31:21, id type enable at 19, eid 17:0
  typedef struct packed {
    logic [SID_W-1:0] sid;
    logic rsv_20;
    logic mask_id_type_enable;
    logic rsv_18;
    logic [EID_W-1:0] eid;
  } caf_mask_t;

  // Message taken from the message assembly buffer
  typedef struct packed {
    logic ide;
    logic [SID_W-1:0] sid;
    logic [EID_W-1:0] eid;
    logic [3:0] dlc;
    logic [DATA_W-1:0] data;
  } caf_msg_t;

  // Store request toward the message fifo memory
  typedef struct packed {
    logic [FIFO_SEL_W-1:0] fifo;
    logic [FILT_IDX_W-1:0] hit;
    caf_msg_t msg;
  } caf_store_t;

  // Values after reset
  localparam caf_filt_ctrl_t FILT_CTRL_RST = 8'h00;
  localparam caf_filt_id_t FILT_ID_RST = 32'h0000_0000;
  localparam caf_mask_t MASK_RST = 32'h0000_0000;
  localparam logic [FILT_IDX_W-1:0] HIT_RST = 5'h00;

  // Engine states, gray along idle, scan, store
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_STORE = 2'b11
  } caf_state_t;

endpackage

// *** design/caf_buffer.sv ***
// Small synchronous fifo holding assembled messages ahead of the filter engine.
// Assumes one clock; a low clock enable freezes it and refuses both sides.
`timescale 1ns/10ps
module caf_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_clock_en,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);

  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two for the wrapping pointers
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
    $error("caf_buffer: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full_w;
  logic empty_w;
  logic push_w;
  logic pop_w;

  // Full when pointers differ only in the wrap bit
  assign full_w = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty_w = (wr_ptr_r == rd_ptr_r);
  assign o_wr_ready = i_clock_en && !full_w;
  assign o_rd_valid = i_clock_en && !empty_w;
  assign push_w = i_wr_valid && o_wr_ready;
  assign pop_w = o_rd_valid && i_rd_ready;
  assign o_rd_data = mem_r[rd_ptr_r[AW-1:0]];

  // Pointer update
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push_w) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop_w) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge i_clock) begin
    if (push_w) mem_r[wr_ptr_r[AW-1:0]] <= i_wr_data;
  end

endmodule

// *** design/caf_filter.sv ***
// Acceptance filter bank and scan engine for received messages.
// Assumes config strobes and fifo status come from logic on the same clock.
`timescale 1ns/10ps
// What this block does
// - Thirty-two filters and four shared masks.
// - Per filter: enable, mask select, fifo select.
// - Scan filters, masked XOR compare, store match.
// - Mask one compares bit, zero ignores it.
// - Enable bit switches filter on and off.
// - Filter writes only in config, normal, disabled.
// - Disabling waits until current filtering ends.
// - Identifier writes ignored while filter enabled.
// - Filters hold 11-bit sid, 18-bit eid.
// - Extended enable selects extended or standard.
// - Type bit clear accepts either format.
// - Type bit set rejects format mismatch.
// - Mask locked while an enabled filter uses it.
// - Mask writes only in configuration mode.
// - Any filter may target any fifo.
// - Latch fifo pointer, store after assembly.
// - Matching filter number into hit field.
// - Lowest matching filter with fifo room wins.
module caf_filter #(
  parameter int NUM_FILTERS = caf_pkg::NUM_FILTERS,
  parameter int BUF_DEPTH = caf_pkg::RX_BUF_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_clock_en,
  input wire logic [2:0] i_operating_mode_field,
  input wire logic i_ctrl_wr_en,
  input wire logic [caf_pkg::FILT_IDX_W-1:0] i_ctrl_wr_idx,
  input wire caf_pkg::caf_filt_ctrl_t i_ctrl_wr_data,
  input wire logic i_filt_wr_en,
  input wire logic [caf_pkg::FILT_IDX_W-1:0] i_filt_wr_idx,
  input wire caf_pkg::caf_filt_id_t i_filt_wr_data,
  input wire logic i_mask_wr_en,
  input wire logic [caf_pkg::MASK_SEL_W-1:0] i_mask_wr_idx,
  input wire caf_pkg::caf_mask_t i_mask_wr_data,
  input wire logic i_msg_valid,
  output logic o_msg_ready,
  input wire caf_pkg::caf_msg_t i_msg,
  input wire logic [caf_pkg::NUM_RX_FIFOS-1:0] i_rx_fifo_full,
  output logic o_store_valid,
  input wire logic i_store_ready,
  output caf_pkg::caf_store_t o_store,
  output logic [caf_pkg::NUM_FILTERS-1:0] o_filter_enable_bits,
  output logic [caf_pkg::FILT_IDX_W-1:0] o_filter_hit_number,
  output logic o_busy
);

  // Filter numbers must fit the five-bit hit and index fields
  if (NUM_FILTERS < 1 || NUM_FILTERS > caf_pkg::NUM_FILTERS) begin : g_bad_param
    $error("caf_filter: NUM_FILTERS must be 1..32");
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  caf_pkg::caf_filt_ctrl_t ctrl_r [NUM_FILTERS];
  caf_pkg::caf_filt_id_t id_r [NUM_FILTERS];
  caf_pkg::caf_mask_t mask_r [caf_pkg::NUM_MASKS];
  logic [NUM_FILTERS-1:0] pend_off_r;
  logic [caf_pkg::NUM_MASKS-1:0] mask_used_w;
  caf_pkg::caf_state_t state_r;
  caf_pkg::caf_state_t state_nxt;
  logic [caf_pkg::FILT_IDX_W-1:0] idx_r;
  caf_pkg::caf_msg_t msg_r;
  caf_pkg::caf_store_t store_r;
  logic [caf_pkg::FILT_IDX_W-1:0] hit_r;
  logic buf_valid_w;
  logic buf_ready_w;
  caf_pkg::caf_msg_t buf_data_w;
  logic busy_w;
  logic mode_ok_w;
  logic mask_mode_ok_w;
  logic pop_w;
  logic take_w;
  logic last_w;
  logic done_w;
  caf_pkg::caf_filt_ctrl_t cand_ctrl_w;
  caf_pkg::caf_filt_id_t cand_id_w;
  caf_pkg::caf_mask_t cand_mask_w;
  logic sid_hit_w;
  logic eid_hit_w;
  logic type_ok_w;
  logic cand_match_w;
  logic cand_room_w;
  caf_pkg::caf_filt_ctrl_t st_ctrl_w;
  caf_pkg::caf_filt_id_t st_id_w;
  caf_pkg::caf_mask_t st_mask_w;

  // Message buffer between assembly and the scan engine
  caf_buffer #(
    .WIDTH($bits(caf_pkg::caf_msg_t)),
    .DEPTH(BUF_DEPTH)
  ) u_rx_buf (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_clock_en(i_clock_en),
    .i_wr_valid(i_msg_valid),
    .o_wr_ready(o_msg_ready),
    .i_wr_data(i_msg),
    .o_rd_valid(buf_valid_w),
    .i_rd_ready(buf_ready_w),
    .o_rd_data(buf_data_w)
  );

  // Mode gating of configuration writes
  assign mode_ok_w = (i_operating_mode_field == caf_pkg::MODE_CONFIG) ||
                     (i_operating_mode_field == caf_pkg::MODE_NORMAL) ||
                     (i_operating_mode_field == caf_pkg::MODE_DISABLE);
  assign mask_mode_ok_w = (i_operating_mode_field == caf_pkg::MODE_CONFIG);
  assign busy_w = (state_r != caf_pkg::ST_IDLE);

  // Candidate filter and its mask for the current scan step
  assign cand_ctrl_w = ctrl_r[idx_r];
  assign cand_id_w = id_r[idx_r];
  assign cand_mask_w = mask_r[cand_ctrl_w.mask_select_field];

  // Masked XOR compare; eid only counts for extended messages
  assign sid_hit_w = ((msg_r.sid ^ cand_id_w.sid) & cand_mask_w.sid) == '0;
  assign eid_hit_w = !msg_r.ide || (((msg_r.eid ^ cand_id_w.eid) & cand_mask_w.eid) == '0);
  // Format check only when the mask asks for it
  assign type_ok_w = !cand_mask_w.mask_id_type_enable ||
                     (msg_r.ide == cand_id_w.extended_id_enable);
  assign cand_match_w = cand_ctrl_w.filter_enable_bit && sid_hit_w && eid_hit_w && type_ok_w;
  // Any filter may name any fifo; full fifo falls through
  assign cand_room_w = !i_rx_fifo_full[cand_ctrl_w.fifo_select_field];

  // Scan step results
  assign take_w = (state_r == caf_pkg::ST_SCAN) && cand_match_w && cand_room_w;
  assign last_w = (idx_r == caf_pkg::FILT_IDX_W'(NUM_FILTERS - 1));
  assign done_w = i_clock_en && (((state_r == caf_pkg::ST_STORE) && i_store_ready) ||
                                 ((state_r == caf_pkg::ST_SCAN) && !take_w && last_w));
  assign buf_ready_w = (state_r == caf_pkg::ST_IDLE);
  assign pop_w = buf_valid_w && buf_ready_w;

  // Next state of the scan engine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      caf_pkg::ST_IDLE: begin
        if (pop_w) state_nxt = caf_pkg::ST_SCAN;
      end
      caf_pkg::ST_SCAN: begin
        if (take_w) state_nxt = caf_pkg::ST_STORE;
        else if (last_w) state_nxt = caf_pkg::ST_IDLE;
      end
      caf_pkg::ST_STORE: begin
        if (i_store_ready) state_nxt = caf_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = caf_pkg::ST_IDLE;
      end
    endcase
  end

  // Engine registers
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= caf_pkg::ST_IDLE;
      idx_r <= '0;
      msg_r <= '0;
    end else if (i_clock_en) begin
      state_r <= state_nxt;
      if (pop_w) msg_r <= buf_data_w;
      if (pop_w) idx_r <= '0;
      else if ((state_r == caf_pkg::ST_SCAN) && !take_w && !last_w) idx_r <= idx_r + 5'h01;
    end
  end

  // Store record and hit number, latched only on an accepted match
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      store_r <= '0;
      hit_r <= caf_pkg::HIT_RST;
    end else if (i_clock_en && take_w) begin
      store_r <= '{fifo: cand_ctrl_w.fifo_select_field, hit: idx_r, msg: msg_r};
      hit_r <= idx_r;
    end
  end

  assign o_store_valid = (state_r == caf_pkg::ST_STORE);
  assign o_store = store_r;
  assign o_filter_hit_number = hit_r;
  assign o_busy = busy_w;

  // Per-filter control and identifier registers
  for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_filt
    logic ctrl_sel_w;
    logic hold_w;
    logic pend_set_w;
    logic pend_clr_w;
    logic id_sel_w;

    assign ctrl_sel_w = i_ctrl_wr_en && mode_ok_w && (i_ctrl_wr_idx == caf_pkg::FILT_IDX_W'(f));
    // An enabled filter is frozen while a message is being filtered
    assign hold_w = busy_w && ctrl_r[f].filter_enable_bit;
    assign pend_set_w = ctrl_sel_w && hold_w && !i_ctrl_wr_data.filter_enable_bit;
    assign pend_clr_w = ctrl_sel_w && hold_w && i_ctrl_wr_data.filter_enable_bit;
    assign id_sel_w = i_filt_wr_en && mode_ok_w && (i_filt_wr_idx == caf_pkg::FILT_IDX_W'(f)) &&
                      !ctrl_r[f].filter_enable_bit;
    assign o_filter_enable_bits[f] = ctrl_r[f].filter_enable_bit;

    // Control byte with deferred disable
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        ctrl_r[f] <= caf_pkg::FILT_CTRL_RST;
        pend_off_r[f] <= 1'b0;
      end else if (i_clock_en) begin
        if (ctrl_sel_w && !hold_w) begin
          ctrl_r[f] <= i_ctrl_wr_data;
          pend_off_r[f] <= 1'b0;
        end else if (done_w && (pend_off_r[f] || pend_set_w) && !pend_clr_w) begin
          ctrl_r[f].filter_enable_bit <= 1'b0;
          pend_off_r[f] <= 1'b0;
        end else if (pend_set_w) begin
          pend_off_r[f] <= 1'b1;
        end else if (pend_clr_w) begin
          pend_off_r[f] <= 1'b0;
        end
      end
    end

    // Identifier word
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) id_r[f] <= caf_pkg::FILT_ID_RST;
      else if (i_clock_en && id_sel_w) id_r[f] <= i_filt_wr_data;
    end

    chk_id_write_lock: assert property (ctrl_r[f].filter_enable_bit |=> id_r[f] == $past(id_r[f]))
      else $error("filter id changed while filter enabled");

    chk_hold_disable: assert property ((busy_w && ctrl_r[f].filter_enable_bit && !done_w)
                                       |=> ctrl_r[f].filter_enable_bit)
      else $error("filter disabled in the middle of filtering");

    // A write to a filter while idle lands at once
    chk_enable_write: assert property ((i_clock_en && ctrl_sel_w && !busy_w) |=>
        o_filter_enable_bits[f] == $past(i_ctrl_wr_data.filter_enable_bit))
      else $error("filter enable write did not take effect");

    // A deferred disable is applied as the message ends
    chk_pending_off: assert property ((done_w && pend_off_r[f] && !pend_clr_w) |=>
        !ctrl_r[f].filter_enable_bit)
      else $error("deferred filter disable not applied");
  end

  // Shared masks, locked while any enabled filter selects them
  for (genvar m = 0; m < caf_pkg::NUM_MASKS; m++) begin : g_mask
    logic [NUM_FILTERS-1:0] user_w;
    logic mask_sel_w;

    for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_user
      assign user_w[f] = ctrl_r[f].filter_enable_bit &&
                         (ctrl_r[f].mask_select_field == caf_pkg::MASK_SEL_W'(m));
    end
    assign mask_used_w[m] = |user_w;
    assign mask_sel_w = i_mask_wr_en && mask_mode_ok_w && !mask_used_w[m] &&
                        (i_mask_wr_idx == caf_pkg::MASK_SEL_W'(m));

    // Mask word
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) mask_r[m] <= caf_pkg::MASK_RST;
      else if (i_clock_en && mask_sel_w) mask_r[m] <= i_mask_wr_data;
    end

    chk_mask_mode: assert property ((i_operating_mode_field != caf_pkg::MODE_CONFIG)
                                    |=> mask_r[m] == $past(mask_r[m]))
      else $error("mask changed outside configuration mode");

    chk_mask_in_use: assert property (mask_used_w[m] |=> $stable(mask_r[m]))
      else $error("mask changed while an enabled filter uses it");
  end

  // Engine checks
  chk_hit_on_store: assert property ((i_clock_en && take_w) |=>
                                     (state_r == caf_pkg::ST_STORE) && (hit_r == $past(idx_r)) &&
                                     (o_store.fifo == $past(cand_ctrl_w.fifo_select_field)))
    else $error("hit number or fifo pointer not latched on match");

  chk_full_skip: assert property ((i_clock_en && (state_r == caf_pkg::ST_SCAN) && cand_match_w &&
                                   !cand_room_w && !last_w) |=>
                                  (state_r == caf_pkg::ST_SCAN) && (idx_r == $past(idx_r) + 5'h01))
    else $error("full fifo did not fall through to next filter");

  chk_discard: assert property ((i_clock_en && (state_r == caf_pkg::ST_SCAN) && last_w && !take_w) |=>
                                (state_r == caf_pkg::ST_IDLE) && !o_store_valid && $stable(hit_r))
    else $error("unmatched message not discarded cleanly");

  chk_store_hold: assert property ((o_store_valid && !(i_store_ready && i_clock_en)) |=>
                                   o_store_valid && $stable(o_store))
    else $error("store request dropped before accepted");

  // Settings of the filter that the pending store names
  assign st_ctrl_w = ctrl_r[o_store.hit];
  assign st_id_w = id_r[o_store.hit];
  assign st_mask_w = mask_r[st_ctrl_w.mask_select_field];

  // A popped message starts a scan at filter zero
  chk_scan_start: assert property ((i_clock_en && pop_w) |=>
      (state_r == caf_pkg::ST_SCAN) && (idx_r == '0) &&
      (msg_r == $past(buf_data_w)))
    else $error("scan did not start at filter zero");

  // A filter that misses hands over to the next one
  chk_scan_step: assert property ((i_clock_en && (state_r == caf_pkg::ST_SCAN) &&
      !cand_match_w && !last_w) |=>
      (state_r == caf_pkg::ST_SCAN) && (idx_r == $past(idx_r) + 5'h01))
    else $error("scan did not advance after a miss");

  // A match with room is taken on the cycle it is seen
  chk_match_taken: assert property ((i_clock_en && (state_r == caf_pkg::ST_SCAN) &&
      cand_match_w && cand_room_w) |=>
      (state_r == caf_pkg::ST_STORE) && (o_filter_hit_number == $past(idx_r)))
    else $error("matching filter with fifo room was passed over");

  // Stored identifier still agrees with its filter under the mask
  chk_store_sid: assert property (o_store_valid |->
      ((o_store.msg.sid ^ st_id_w.sid) & st_mask_w.sid) == '0)
    else $error("stored message fails its filter sid compare");

  // Extended messages must also agree in the extension bits
  chk_store_eid: assert property ((o_store_valid && o_store.msg.ide) |->
      ((o_store.msg.eid ^ st_id_w.eid) & st_mask_w.eid) == '0)
    else $error("stored message fails its filter eid compare");

  // A type-checking mask only passes the filter's own format
  chk_store_format: assert property ((o_store_valid && st_mask_w.mask_id_type_enable) |->
      o_store.msg.ide == st_id_w.extended_id_enable)
    else $error("stored message has the wrong format for its filter");

  // The store names the enabled hit filter's own fifo
  chk_store_fifo: assert property (o_store_valid |->
      st_ctrl_w.filter_enable_bit &&
      (o_store.fifo == st_ctrl_w.fifo_select_field))
    else $error("store fifo differs from the hit filter select");

  // Control writes in a barred mode leave every enable alone
  chk_mode_gate: assert property ((i_ctrl_wr_en && !mode_ok_w && !busy_w) |=>
      $stable(o_filter_enable_bits))
    else $error("control write accepted in a barred mode");

  // The hit number only moves on an accepted match
  chk_hit_kept: assert property (!(i_clock_en && take_w) |=> $stable(hit_r))
    else $error("hit number changed without a match");

endmodule

// *** test/caf_rx_model.sv ***
// Far-side model: message fifo memory that takes store requests.
// Assumes the filter's clock and reset; stall comes from the bench.
`timescale 1ns/10ps
module caf_rx_model (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_stall,
  input wire logic i_store_valid,
  input wire caf_pkg::caf_store_t i_store,
  output logic o_store_ready,
  output logic [31:0] o_count,
  output caf_pkg::caf_store_t o_last
);
  // Ready only while not stalled
  assign o_store_ready = !i_stall;

  // Count and keep each store taken
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_count <= 32'h0;
      o_last <= '0;
    end else if (i_store_valid && o_store_ready) begin
      o_count <= o_count + 32'h1;
      o_last <= i_store;
    end
  end
endmodule

// *** test/caf_filter_bench.sv ***
// Self-checking bench for the acceptance filter bank.
// Assumes caf_pkg, caf_buffer and caf_filter are compiled first.
`timescale 1ns/10ps
module caf_filter_bench;
  logic i_clock, i_reset_n, i_clock_en, stall;
  logic [2:0] mode;
  logic c_en, f_en, m_en, i_msg_valid, o_msg_ready, o_store_valid, o_busy, ready;
  logic [4:0] c_idx, f_idx, o_filter_hit_number;
  logic [1:0] m_idx;
  caf_pkg::caf_filt_ctrl_t c_data;
  caf_pkg::caf_filt_id_t f_data;
  caf_pkg::caf_mask_t m_data;
  caf_pkg::caf_msg_t i_msg;
  caf_pkg::caf_store_t o_store, last;
  logic [31:0] full, ena, cnt, seen;
  int errors, check_count, n, k;

  caf_filter i_dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_clock_en(i_clock_en),
    .i_operating_mode_field(mode), .i_ctrl_wr_en(c_en), .i_ctrl_wr_idx(c_idx),
    .i_ctrl_wr_data(c_data), .i_filt_wr_en(f_en), .i_filt_wr_idx(f_idx),
    .i_filt_wr_data(f_data), .i_mask_wr_en(m_en), .i_mask_wr_idx(m_idx),
    .i_mask_wr_data(m_data), .i_msg_valid(i_msg_valid), .o_msg_ready(o_msg_ready),
    .i_msg(i_msg), .i_rx_fifo_full(full), .o_store_valid(o_store_valid),
    .i_store_ready(ready), .o_store(o_store), .o_filter_enable_bits(ena),
    .o_filter_hit_number(o_filter_hit_number), .o_busy(o_busy));
  caf_rx_model u_model (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_stall(stall),
    .i_store_valid(o_store_valid), .i_store(o_store), .o_store_ready(ready),
    .o_count(cnt), .o_last(last));

  // Clock, 4 ns period
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  task automatic cyc;
    @(posedge i_clock);
    #1;
  endtask

  task automatic final_report;
    $display("Checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tmo(input string what);
    errors++;
    $display("Error %s expected completion seen timeout", what);
    final_report;
  endtask

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  function automatic logic [31:0] fw(input logic [10:0] s, input logic x, input logic [17:0] e);
    fw = {s, 1'b0, x, 1'b0, e};
  endfunction

  function automatic caf_pkg::caf_msg_t mk(input logic ide, input logic [10:0] s,
                                           input logic [17:0] e, input logic [63:0] d);
    mk = {ide, s, e, 4'h8, d};
  endfunction

  // One config write: 0 control, 1 identifier, 2 mask; strobe lasts one cycle
  task automatic cfg(input int kind, input logic [4:0] idx, input logic [31:0] d);
    case (kind)
      0: begin c_en = 1'b1; c_idx = idx; c_data = d[7:0]; end
      1: begin f_en = 1'b1; f_idx = idx; f_data = d; end
      default: begin m_en = 1'b1; m_idx = idx[1:0]; m_data = d; end
    endcase
    cyc;
    c_en = 1'b0;
    f_en = 1'b0;
    m_en = 1'b0;
    cyc;
  endtask

  // Offer one message and hold it until taken
  task automatic send(input caf_pkg::caf_msg_t m);
    int w;
    w = 0;
    i_msg = m;
    i_msg_valid = 1'b1;
    while (o_msg_ready !== 1'b1 && w < 100) begin cyc; w++; end
    if (o_msg_ready !== 1'b1) tmo("msg ready");
    cyc;
    i_msg_valid = 1'b0;
    i_msg = ~m;
  endtask

  task automatic expect_store(input logic [4:0] f, input logic [4:0] h, input logic [31:0] d);
    int w;
    w = 0;
    while (cnt === seen && w < 80) begin cyc; w++; end
    if (cnt === seen) tmo("store");
    seen++;
    check("store fifo", f, last.fifo);
    check("store hit", h, last.hit);
    check("hit field", h, o_filter_hit_number);
    check("store data", d, last.msg.data[31:0]);
  endtask

  task automatic expect_none(input logic [4:0] h);
    repeat (45) cyc;
    check("store count", seen, cnt);
    check("hit field", h, o_filter_hit_number);
  endtask

  // Main sequence
  initial begin
    i_reset_n = 1'b0; i_clock_en = 1'b1; stall = 1'b0; mode = caf_pkg::MODE_CONFIG;
    c_en = 1'b0; f_en = 1'b0; m_en = 1'b0; c_idx = 5'h0; f_idx = 5'h0; m_idx = 2'h0;
    c_data = '0; f_data = '0; m_data = '0; i_msg = '0; i_msg_valid = 1'b0; full = 32'h0;
    errors = 0; check_count = 0; seen = 32'h0;
    repeat (10) cyc;
    i_reset_n = 1'b1;
    cyc;
    check("enables", 32'h0, ena);
    check("busy", 32'h0, o_busy);
    check("hit field", 32'h0, o_filter_hit_number);
    // Filter 3 range 0x100..0x103, standard only; filters 1,2,4 type-blind
    cfg(1, 5'd3, fw(11'h100, 1'b0, 18'h0));
    cfg(2, 5'd1, fw(11'h7fc, 1'b1, 18'h0));
    cfg(0, 5'd3, {24'h0, 1'b1, 2'd1, 5'd5});
    // Mask 0 is locked once its filters are on, so load it first
    cfg(2, 5'd0, fw(11'h7ff, 1'b0, 18'h3ffff));
    for (k = 1; k < 5; k++) begin
      if (k != 3) cfg(1, k[4:0], fw(11'h0aa, 1'b0, 18'h1c498));
      if (k != 3) cfg(0, k[4:0], {24'h0, 1'b1, 2'd0, (k == 1) ? 5'd7 : k[4:0]});
    end
    check("enables", 32'h1e, ena);
    mode = caf_pkg::MODE_NORMAL;
    send(mk(1'b0, 11'h102, 18'h0, 64'h11));
    expect_store(5'd5, 5'd3, 32'h11);
    send(mk(1'b0, 11'h104, 18'h0, 64'h12));
    expect_none(5'd3);
    send(mk(1'b1, 11'h100, 18'h0, 64'h13));
    expect_none(5'd3);
    send(mk(1'b1, 11'h0aa, 18'h1c498, 64'h14));
    expect_store(5'd7, 5'd1, 32'h14);
    full = 32'h84;
    send(mk(1'b1, 11'h0aa, 18'h1c498, 64'h15));
    expect_store(5'd4, 5'd4, 32'h15);
    full = 32'h0;
    cfg(1, 5'd3, fw(11'h200, 1'b0, 18'h0));
    send(mk(1'b0, 11'h101, 18'h0, 64'h16));
    expect_store(5'd5, 5'd3, 32'h16);
    // Mask 1 opened fully would admit 0x300; both writes must be dropped
    cfg(2, 5'd1, 32'h0);
    send(mk(1'b0, 11'h300, 18'h0, 64'h17));
    expect_none(5'd3);
    mode = caf_pkg::MODE_CONFIG;
    cfg(2, 5'd1, 32'h0);
    send(mk(1'b0, 11'h300, 18'h0, 64'h18));
    expect_none(5'd3);
    // Control writes only in the three allowed modes
    mode = 3'h2;
    cfg(0, 5'd5, {24'h0, 1'b1, 7'h0});
    check("enables", 32'h1e, ena);
    mode = caf_pkg::MODE_DISABLE;
    cfg(0, 5'd5, {24'h0, 1'b1, 7'h0});
    check("enables", 32'h3e, ena);
    cfg(0, 5'd5, 32'h0);
    mode = caf_pkg::MODE_NORMAL;
    // Disable while a hitting message is held in the store stage
    stall = 1'b1;
    send(mk(1'b0, 11'h103, 18'h0, 64'h19));
    k = 0;
    while (o_store_valid !== 1'b1 && k < 60) begin cyc; k++; end
    if (o_store_valid !== 1'b1) tmo("store valid");
    cfg(0, 5'd3, 32'h0);
    check("enable held", 32'h1, ena[3]);
    stall = 1'b0;
    expect_store(5'd5, 5'd3, 32'h19);
    k = 0;
    while (ena[3] !== 1'b0 && k < 10) begin cyc; k++; end
    check("enable cleared", 32'h0, ena[3]);
    // Fill the buffer with the far side stalled, then drain in order
    stall = 1'b1;
    n = 0;
    for (k = 0; k < 12; k++) begin
      if (o_msg_ready !== 1'b1) break;
      i_msg = mk(1'b0, 11'h0aa, 18'h0, 64'(k));
      i_msg_valid = 1'b1;
      cyc;
      n++;
    end
    i_msg_valid = 1'b0;
    i_msg = ~i_msg;
    check("accepted", caf_pkg::RX_BUF_DEPTH + 1, n);
    stall = 1'b0;
    for (k = 0; k < n; k++) expect_store(5'd7, 5'd1, k);
    cyc;
    check("busy", 32'h0, o_busy);
    i_clock_en = 1'b0;
    cyc;
    check("ready frozen", 32'h0, o_msg_ready);
    i_clock_en = 1'b1;
    cyc;
    check("enables", 32'h16, ena);
    final_report;
  end
endmodule
